// *** design/fuse_config_decoder.sv ***
`timescale 1ns/1ps
`include "fuse_config_defines.svh"
// Behaviour
// - At load the oscillator lock fuse bit becomes the calibration lock, 1 locking trim writes.
// - Frequency code 0x1 runs the main oscillator at 16 MHz and 0x2 at 20 MHz.
// - The frequency code picks which factory trim pair is loaded into the trim fields.
// - The CRC field selects full Flash, boot, boot plus code, or no scan.
// - A chip erase erases EEPROM when the retention bit is 0 and, on an open device, keeps it when 1.
// - A locked device always erases EEPROM on chip erase.
// - The start-up code selects 0, 1, 2, 4, 8, 16, 32 or 64 ms before code runs.
// - The code limit marks the end of boot plus application code in 256-byte blocks.
// - Flash above the code end is the application data section.
// - A code limit of 0x00 makes all Flash from the boot end onward application code.
// - The boot limit marks the end of the boot section in 256-byte blocks.
// - A boot limit of 0x00 makes the whole Flash the boot section.
// - The device is open only when the key byte equals 0xC5, else locked.
// - A locked device keeps the debug port off the system bus.
// - Fuses sit at 0x1280, the signature row at 0x1100 and the user row at 0x1300.
// - At load the watchdog window and period fields go to the watchdog control.
module fuse_config_decoder #(
  parameter int MS_CYCLES = `FC_MS_NS / `FC_CLK_NS
) (
  input logic ref_clk,
  input logic rst,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fuseReq,
  output logic [3:0] fuseAddr,
  input logic fuseAck,
  input logic [7:0] fuseData,
  input logic [7:0] cal16FreqTrim,
  input logic [7:0] cal16TempTrim,
  input logic [7:0] cal20FreqTrim,
  input logic [7:0] cal20TempTrim,
  output logic configValid,
  output logic oscCalLock,
  output logic osc20MHz,
  output logic [7:0] oscFreqTrim,
  output logic [7:0] oscTempTrim,
  output fuse_config_pkg::crc_range_e crcScanRange,
  input logic chipErase,
  output logic eraseEeprom,
  output logic [15:0] bootEndAddr,
  output logic [15:0] appEndAddr,
  output logic [3:0] wdtWindow,
  output logic [3:0] wdtPeriod,
  output logic deviceOpen,
  input logic dbgBusReq,
  output logic dbgBusGrant,
  input logic [15:0] dataAddr,
  output logic selSigRow,
  output logic selFuse,
  output logic selUserRow,
  output logic codeRun
);
  import fuse_config_pkg::*;

  fuse_load_if ldBus();

  fuse_loader uLoader (
    .ref_clk(ref_clk),
    .rst(rst),
    .fuseReq(fuseReq),
    .fuseAddr(fuseAddr),
    .fuseAck(fuseAck),
    .fuseData(fuseData),
    .ld(ldBus.loader)
  );

  logic [7:0] fuse [0:10];
  logic [7:0] next_fuse [0:10];
  logic apply;
  logic next_configValid, next_oscCalLock, next_osc20MHz, next_deviceOpen;
  logic [7:0] next_oscFreqTrim, next_oscTempTrim, keyStage, next_keyStage;
  crc_range_e next_crcScanRange;
  logic retain, next_retain, next_eraseEeprom;
  logic [15:0] next_bootEndAddr, next_appEndAddr;
  logic [3:0] next_wdtWindow, next_wdtPeriod;
  logic [5:0] regIdx;
  logic wrHit;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // Fuse shadow; only the loader writes it, so contents hold until the next reset.
  always_comb begin
    for (int i = 0; i <= 10; i++) begin
      next_fuse[i] = fuse[i];
    end
    if (ldBus.wrEn) begin
      next_fuse[ldBus.wrIdx] = ldBus.wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i <= 10; i++) begin
        fuse[i] <= `FC_RST_ZERO;
      end
      fuse[2] <= `FC_RST_OSC;
      fuse[5] <= `FC_RST_SYSA;
      fuse[6] <= `FC_RST_START;
    end else begin
      for (int i = 0; i <= 10; i++) begin
        fuse[i] <= next_fuse[i];
      end
    end
  end

  assign apply = ldBus.done & ~configValid;
  assign regIdx = paddr[7:2];
  assign wrHit = psel & penable & pwrite;

  always_comb begin
    next_configValid = configValid;
    next_oscCalLock = oscCalLock;
    next_osc20MHz = osc20MHz;
    next_oscFreqTrim = oscFreqTrim;
    next_oscTempTrim = oscTempTrim;
    next_crcScanRange = crcScanRange;
    next_retain = retain;
    next_deviceOpen = deviceOpen;
    next_bootEndAddr = bootEndAddr;
    next_appEndAddr = appEndAddr;
    next_wdtWindow = wdtWindow;
    next_wdtPeriod = wdtPeriod;
    next_keyStage = keyStage;
    if (apply) begin
      next_configValid = 1'b1;
      next_oscCalLock = fuse[2][`FC_LOCK_BIT];
      if (fuse[2][`FC_FREQ_RNG] == `FC_FREQ_16) begin
        next_osc20MHz = 1'b0;
      end else if (fuse[2][`FC_FREQ_RNG] == `FC_FREQ_20) begin
        next_osc20MHz = 1'b1;
      end
      next_oscFreqTrim = next_osc20MHz ? cal20FreqTrim : cal16FreqTrim;
      next_oscTempTrim = next_osc20MHz ? cal20TempTrim : cal16TempTrim;
      next_crcScanRange = crc_range_e'(fuse[5][`FC_CRC_RNG]);
      next_retain = fuse[5][`FC_RETAIN_BIT];
      next_deviceOpen = (fuse[10] == `FC_OPEN_KEY);
      next_keyStage = fuse[10];
      next_bootEndAddr = (fuse[8] == 8'h00) ? `FC_FLASH_BYTES : {fuse[8], 8'h00};
      next_appEndAddr = (fuse[7] == 8'h00) ? `FC_FLASH_BYTES : {fuse[7], 8'h00};
      next_wdtWindow = fuse[0][`FC_WIN_RNG];
      next_wdtPeriod = fuse[0][`FC_PER_RNG];
    end else if (wrHit && configValid) begin
      if (regIdx == `FC_IDX_TRIM && !oscCalLock) begin
        next_oscFreqTrim = pwdata[`FC_TRIM_F_RNG];
        next_oscTempTrim = pwdata[`FC_TRIM_T_RNG];
      end
      // An APB write to the key register updates the staged key; the lock state keeps its load value.
      if (regIdx == `FC_IDX_KEY) begin
        next_keyStage = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      configValid <= 1'b0;
      oscCalLock <= 1'b0;
      osc20MHz <= 1'b1;
      oscFreqTrim <= 8'h00;
      oscTempTrim <= 8'h00;
      crcScanRange <= CRC_NONE;
      retain <= 1'b0;
      deviceOpen <= 1'b0;
      bootEndAddr <= `FC_FLASH_BYTES;
      appEndAddr <= `FC_FLASH_BYTES;
      wdtWindow <= 4'h0;
      wdtPeriod <= 4'h0;
      keyStage <= `FC_RST_ZERO;
    end else begin
      configValid <= next_configValid;
      oscCalLock <= next_oscCalLock;
      osc20MHz <= next_osc20MHz;
      oscFreqTrim <= next_oscFreqTrim;
      oscTempTrim <= next_oscTempTrim;
      crcScanRange <= next_crcScanRange;
      retain <= next_retain;
      deviceOpen <= next_deviceOpen;
      bootEndAddr <= next_bootEndAddr;
      appEndAddr <= next_appEndAddr;
      wdtWindow <= next_wdtWindow;
      wdtPeriod <= next_wdtPeriod;
      keyStage <= next_keyStage;
    end
  end

  always_comb begin
    next_eraseEeprom = chipErase & (~retain | ~deviceOpen);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eraseEeprom <= 1'b0;
    end else begin
      eraseEeprom <= next_eraseEeprom;
    end
  end

  assign dbgBusGrant = dbgBusReq & deviceOpen & configValid;

  assign selSigRow = (dataAddr >= `FC_SIG_BASE) && (dataAddr < `FC_SIG_BASE + `FC_REGION_SPAN);
  assign selFuse = (dataAddr >= `FC_FUSE_BASE) && (dataAddr < `FC_FUSE_BASE + `FC_REGION_SPAN);
  assign selUserRow = (dataAddr >= `FC_USER_BASE) &&
                      (dataAddr < `FC_USER_BASE + `FC_REGION_SPAN);

  startup_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) uTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(apply),
    .code(fuse[6][`FC_START_RNG]),
    .codeRun(codeRun)
  );

  // Read data is captured in the setup cycle, so every access finishes in one wait-free cycle.
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = 32'h00000000;
      case (regIdx)
        `FC_IDX_WDT, `FC_IDX_OSC, `FC_IDX_SYSA, `FC_IDX_START, `FC_IDX_APP,
        `FC_IDX_BOOT: begin
          next_prdata = {24'h000000, fuse[regIdx[3:0]]};
        end
        `FC_IDX_KEY: begin
          next_prdata = {24'h000000, keyStage};
        end
        `FC_IDX_BOD, `FC_IDX_RSV3, `FC_IDX_RSV4, `FC_IDX_RSV9: begin
          next_prdata = 32'h00000000;
        end
        `FC_IDX_TRIM: begin
          next_prdata = {16'h0000, oscTempTrim, oscFreqTrim};
        end
        `FC_IDX_STATUS: begin
          next_prdata = {24'h000000, crcScanRange, 1'b0, codeRun, oscCalLock, osc20MHz,
                         deviceOpen, configValid};
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable) begin
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign pready = penable;

  property p_lock_copy;
    @(posedge ref_clk) disable iff (rst)
    apply |=> (oscCalLock == $past(fuse[2][`FC_LOCK_BIT]));
  endproperty
  a_lock_copy: assert property (p_lock_copy) else $error("lock bit not copied");

  property p_freq16;
    @(posedge ref_clk) disable iff (rst)
    apply && fuse[2][`FC_FREQ_RNG] == `FC_FREQ_16
      |=> !osc20MHz && oscFreqTrim == $past(cal16FreqTrim);
  endproperty
  a_freq16: assert property (p_freq16) else $error("16 MHz select wrong");

  property p_freq_reserved;
    @(posedge ref_clk) disable iff (rst)
    apply && fuse[2][`FC_FREQ_RNG] != `FC_FREQ_16 && fuse[2][`FC_FREQ_RNG] != `FC_FREQ_20
      |=> $stable(osc20MHz);
  endproperty
  a_freq_reserved: assert property (p_freq_reserved) else $error("reserved code acted");

  property p_crc;
    @(posedge ref_clk) disable iff (rst)
    configValid |-> crcScanRange == crc_range_e'(fuse[5][`FC_CRC_RNG]);
  endproperty
  a_crc: assert property (p_crc) else $error("scan range mismatch");

  property p_locked_erase;
    @(posedge ref_clk) disable iff (rst)
    chipErase && configValid && !deviceOpen |=> eraseEeprom;
  endproperty
  a_locked_erase: assert property (p_locked_erase) else $error("locked erase kept EEPROM");

  property p_retain;
    @(posedge ref_clk) disable iff (rst)
    chipErase && deviceOpen && retain ##1 !apply |-> !eraseEeprom;
  endproperty
  a_retain: assert property (p_retain) else $error("retained EEPROM erased");

  property p_key;
    @(posedge ref_clk) disable iff (rst)
    configValid |-> deviceOpen == (fuse[10] == `FC_OPEN_KEY);
  endproperty
  a_key: assert property (p_key) else $error("open state mismatch");

  property p_dbg_block;
    @(posedge ref_clk) disable iff (rst)
    !deviceOpen |-> !dbgBusGrant;
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug reached bus while locked");

  property p_boot_whole;
    @(posedge ref_clk) disable iff (rst)
    configValid && fuse[8] == 8'h00 |-> bootEndAddr == `FC_FLASH_BYTES;
  endproperty
  a_boot_whole: assert property (p_boot_whole) else $error("boot end not whole Flash");

  property p_wdt;
    @(posedge ref_clk) disable iff (rst)
    configValid |-> wdtWindow == fuse[0][`FC_WIN_RNG] && wdtPeriod == fuse[0][`FC_PER_RNG];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog fields wrong");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
    configValid |=> configValid && $stable(bootEndAddr) && $stable(deviceOpen);
  endproperty
  a_hold: assert property (p_hold) else $error("decoded values moved");
endmodule

// *** design/fuse_config_defines.svh ***
`ifndef FUSE_CONFIG_DEFINES_SVH
`define FUSE_CONFIG_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define FC_IDX_WDT 6'h00
`define FC_IDX_BOD 6'h01
`define FC_IDX_OSC 6'h02
`define FC_IDX_RSV3 6'h03
`define FC_IDX_RSV4 6'h04
`define FC_IDX_SYSA 6'h05
`define FC_IDX_START 6'h06
`define FC_IDX_APP 6'h07
`define FC_IDX_BOOT 6'h08
`define FC_IDX_RSV9 6'h09
`define FC_IDX_KEY 6'h0A
`define FC_IDX_TRIM 6'h10
`define FC_IDX_STATUS 6'h11
`define FC_FUSE_LAST 4'hA

// Field positions.
`define FC_LOCK_BIT 7
`define FC_FREQ_RNG 1:0
`define FC_CRC_RNG 7:6
`define FC_RETAIN_BIT 0
`define FC_START_RNG 2:0
`define FC_WIN_RNG 7:4
`define FC_PER_RNG 3:0
`define FC_TRIM_F_RNG 7:0
`define FC_TRIM_T_RNG 15:8

// Codes and reset values.
`define FC_FREQ_16 2'h1
`define FC_FREQ_20 2'h2
`define FC_OPEN_KEY 8'hC5
`define FC_RST_OSC 8'h02
`define FC_RST_SYSA 8'hC4
`define FC_RST_START 8'h07
`define FC_RST_ZERO 8'h00
`define FC_FLASH_BYTES 16'h1000

// Data space map.
`define FC_SIG_BASE 16'h1100
`define FC_FUSE_BASE 16'h1280
`define FC_USER_BASE 16'h1300
`define FC_REGION_SPAN 16'h0080

// Timing.
`define FC_MS_NS 1000000
`define FC_CLK_NS 8

`endif

// *** design/fuse_config_pkg.sv ***
package fuse_config_pkg;
  typedef enum logic [1:0] {CRC_FULL, CRC_BOOT, CRC_BOOT_CODE, CRC_NONE} crc_range_e;
  typedef enum logic [1:0] {LD_FETCH, LD_DONE} load_state_e;
  typedef enum logic [1:0] {TM_IDLE, TM_COUNT, TM_RUN} timer_state_e;
endpackage

// *** design/fuse_load_if.sv ***
`timescale 1ns/1ps
interface fuse_load_if;
  logic wrEn;
  logic [3:0] wrIdx;
  logic [7:0] wrData;
  logic done;
  modport loader(output wrEn, output wrIdx, output wrData, output done);
  modport sink(input wrEn, input wrIdx, input wrData, input done);
endinterface

// *** design/fuse_loader.sv ***
`timescale 1ns/1ps
`include "fuse_config_defines.svh"
module fuse_loader (
  input logic ref_clk,
  input logic rst,
  output logic fuseReq,
  output logic [3:0] fuseAddr,
  input logic fuseAck,
  input logic [7:0] fuseData,
  fuse_load_if.loader ld
);
  import fuse_config_pkg::*;
  load_state_e state, next_state;
  logic [3:0] idx, next_idx;

  // Fuse bytes are fetched once per reset; after the last one the loader rests.
  always_comb begin
    next_state = state;
    next_idx = idx;
    case (state)
      LD_FETCH: begin
        if (fuseAck) begin
          if (idx == `FC_FUSE_LAST) begin
            next_state = LD_DONE;
          end else begin
            next_idx = idx + 4'h1;
          end
        end
      end
      LD_DONE: begin
      end
      default: next_state = LD_FETCH;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= LD_FETCH;
      idx <= 4'h0;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  assign fuseReq = (state == LD_FETCH);
  assign fuseAddr = idx;
  assign ld.wrEn = fuseReq & fuseAck;
  assign ld.wrIdx = idx;
  assign ld.wrData = fuseData;
  assign ld.done = (state == LD_DONE);
endmodule

// *** design/startup_timer.sv ***
`timescale 1ns/1ps
module startup_timer #(
  parameter int MS_CYCLES = 125000
) (
  input logic ref_clk,
  input logic rst,
  input logic start,
  input logic [2:0] code,
  output logic codeRun
);
  import fuse_config_pkg::*;
  timer_state_e state, next_state;
  logic [16:0] pre, next_pre;
  logic [6:0] msLeft, next_msLeft;

  always_comb begin
    next_state = state;
    next_pre = pre;
    next_msLeft = msLeft;
    case (state)
      TM_IDLE: begin
        if (start) begin
          next_pre = 17'h00000;
          next_msLeft = (code == 3'h0) ? 7'h00 : (7'h01 << (code - 3'h1));
          next_state = (code == 3'h0) ? TM_RUN : TM_COUNT;
        end
      end
      TM_COUNT: begin
        if (pre == 17'(MS_CYCLES - 1)) begin
          next_pre = 17'h00000;
          next_msLeft = msLeft - 7'h01;
          if (msLeft == 7'h01) begin
            next_state = TM_RUN;
          end
        end else begin
          next_pre = pre + 17'h00001;
        end
      end
      TM_RUN: begin
      end
      default: next_state = TM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= TM_IDLE;
      pre <= 17'h00000;
      msLeft <= 7'h00;
    end else begin
      state <= next_state;
      pre <= next_pre;
      msLeft <= next_msLeft;
    end
  end

  assign codeRun = (state == TM_RUN);
endmodule

// *** dv/fuse_store_model.sv ***
`timescale 1ns/1ps
module fuse_store_model (
  input logic ref_clk,
  input logic fuseReq,
  input logic [3:0] fuseAddr,
  input logic [10:0][7:0] image,
  input logic slow,
  output logic fuseAck,
  output logic [7:0] fuseData
);
  logic gate = 1'b0;
  logic [7:0] last = 8'h00;

  // A slow store answers only every other cycle, so the loader must wait.
  always @(posedge ref_clk) begin
    gate <= ~gate;
    if (fuseAck) begin
      last <= fuseData;
    end
  end

  always_comb begin
    fuseAck = fuseReq & (gate | ~slow);
    // Between answers the data lines carry no stale byte.
    fuseData = ~last;
    if (fuseAck && fuseAddr <= 4'hA) begin
      fuseData = image[fuseAddr];
    end
  end
endmodule

// *** dv/fuse_config_decoder_bench.sv ***
`timescale 1ns/1ps
module fuse_config_decoder_bench;
  import fuse_config_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, fuseReq, fuseAck, configValid, oscCalLock, osc20MHz;
  logic eraseEeprom, deviceOpen, dbgBusGrant, selSigRow, selFuse, selUserRow, codeRun;
  logic [3:0] fuseAddr, wdtWindow, wdtPeriod;
  logic [7:0] fuseData, oscFreqTrim, oscTempTrim;
  logic [10:0][7:0] image = '0;
  logic slow = 1'b0;
  logic chipErase = 1'b0;
  logic dbgBusReq = 1'b0;
  logic [15:0] dataAddr = 16'h0;
  logic [15:0] bootEndAddr, appEndAddr, expAddr;
  crc_range_e crcScanRange;
  logic [31:0] q;
  logic e, lock, f20, open, erase;
  int n, d;
  int badCount = 0;
  int testsRun = 0;
  localparam logic [7:0] OSC [0:3] = '{8'h82, 8'h01, 8'h03, 8'h02};
  localparam logic [7:0] SYSA [0:3] = '{8'h41, 8'h80, 8'h01, 8'hC0};
  localparam logic [7:0] STARTUP [0:3] = '{8'h00, 8'h03, 8'h01, 8'h07};
  localparam logic [7:0] APP [0:3] = '{8'h08, 8'h00, 8'h10, 8'h00};
  localparam logic [7:0] BOOT [0:3] = '{8'h04, 8'h03, 8'h02, 8'h00};
  localparam logic [7:0] KEY [0:3] = '{8'hC5, 8'h00, 8'h12, 8'hC5};
  localparam logic [7:0] WDT [0:3] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
  localparam logic [15:0] DA [0:7] = '{16'h10FF, 16'h1100, 16'h117F, 16'h1180,
                                       16'h1280, 16'h12FF, 16'h1300, 16'h137F};

  always #4 ref_clk = ~ref_clk;

  fuse_config_decoder #(.MS_CYCLES(10)) i_fuse_config_decoder (
    .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuseReq(fuseReq), .fuseAddr(fuseAddr), .fuseAck(fuseAck),
    .fuseData(fuseData), .cal16FreqTrim(8'h16), .cal16TempTrim(8'h61),
    .cal20FreqTrim(8'h20), .cal20TempTrim(8'h02), .configValid(configValid),
    .oscCalLock(oscCalLock), .osc20MHz(osc20MHz), .oscFreqTrim(oscFreqTrim),
    .oscTempTrim(oscTempTrim), .crcScanRange(crcScanRange), .chipErase(chipErase),
    .eraseEeprom(eraseEeprom), .bootEndAddr(bootEndAddr), .appEndAddr(appEndAddr),
    .wdtWindow(wdtWindow), .wdtPeriod(wdtPeriod), .deviceOpen(deviceOpen),
    .dbgBusReq(dbgBusReq), .dbgBusGrant(dbgBusGrant), .dataAddr(dataAddr),
    .selSigRow(selSigRow), .selFuse(selFuse), .selUserRow(selUserRow), .codeRun(codeRun)
  );

  fuse_store_model i_fuse_store_model (
    .ref_clk(ref_clk), .fuseReq(fuseReq), .fuseAddr(fuseAddr), .image(image),
    .slow(slow), .fuseAck(fuseAck), .fuseData(fuseData)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      chk(32'h0, 32'h1);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    conclude();
  end

  initial begin
    for (int t = 0; t < 4; t++) begin
      @(posedge ref_clk);
      rst <= 1'b1;
      slow <= (t % 3 == 0);
      image <= {KEY[t], 8'h77, BOOT[t], APP[t], STARTUP[t], SYSA[t], 8'h77, 8'h77,
                OSC[t], 8'h77, WDT[t]};
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      if (t == 0) begin
        apb(8'h14, 1'b0, 32'h0, q, e);
        chk(q, 32'h0000_00C4);
      end
      n = 0;
      while (configValid !== 1'b1 && n < 200) begin
        @(posedge ref_clk);
        n++;
      end
      // A load that never finishes must count as a mismatch, not slip through.
      chk(32'(configValid), 32'h1);
      n = 0;
      while (codeRun !== 1'b1 && n < 1000) begin
        @(posedge ref_clk);
        n++;
      end
      d = (STARTUP[t] == 8'h00) ? 1 : (1 << (STARTUP[t] - 1)) * 10 + 1;
      chk(32'(n >= d - 1 && n <= d + 1), 32'h1);
      lock = OSC[t][7];
      f20 = (OSC[t][1:0] != 2'h1);
      open = (KEY[t] == 8'hC5);
      erase = ~SYSA[t][0] | ~open;
      chk(32'(oscCalLock), 32'(lock));
      chk(32'(osc20MHz), 32'(f20));
      chk(32'({oscTempTrim, oscFreqTrim}), f20 ? 32'h0220 : 32'h6116);
      chk(32'(crcScanRange), 32'(SYSA[t][7:6]));
      chk(32'(bootEndAddr), BOOT[t] == 8'h0 ? 32'h1000 : 32'({BOOT[t], 8'h0}));
      chk(32'(appEndAddr), APP[t] == 8'h0 ? 32'h1000 : 32'({APP[t], 8'h0}));
      chk(32'({wdtWindow, wdtPeriod}), 32'(WDT[t]));
      chk(32'(deviceOpen), 32'(open));
      @(posedge ref_clk);
      dbgBusReq <= 1'b1;
      chipErase <= 1'b1;
      @(posedge ref_clk);
      chipErase <= 1'b0;
      chk(32'(dbgBusGrant), 32'(open));
      @(posedge ref_clk);
      dbgBusReq <= 1'b0;
      chk(32'(eraseEeprom), 32'(erase));
      for (int i = 0; i <= 10; i++) begin
        apb(8'(4 * i), 1'b0, 32'h0, q, e);
        chk(q, (i == 1 || i == 3 || i == 4 || i == 9) ? 32'h0 : 32'(image[i]));
        chk(32'(e), 32'h0);
      end
      apb(8'h44, 1'b0, 32'h0, q, e);
      chk(q, 32'({SYSA[t][7:6], 2'b01, lock, f20, open, 1'b1}));
      apb(8'h48, 1'b0, 32'h0, q, e);
      chk(32'(e), 32'h1);
      apb(8'h40, 1'b1, 32'h0000_5AA5, q, e);
      apb(8'h40, 1'b0, 32'h0, q, e);
      chk(q, lock ? (f20 ? 32'h0220 : 32'h6116) : 32'h5AA5);
      apb(8'h28, 1'b1, 32'h0000_0033, q, e);
      apb(8'h28, 1'b0, 32'h0, q, e);
      chk(q, 32'h33);
      image <= ~image;
      repeat (12) @(posedge ref_clk);
      chk(32'({fuseReq, deviceOpen, osc20MHz}), 32'({1'b0, open, f20}));
      chk(32'(crcScanRange), 32'(SYSA[t][7:6]));
      $display("Test %0d done", t);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      dataAddr <= DA[i];
      @(posedge ref_clk);
      expAddr = DA[i];
      chk(32'({selSigRow, selFuse, selUserRow}), 32'({expAddr[15:7] == 9'h022,
          expAddr[15:7] == 9'h025, expAddr[15:7] == 9'h026}));
    end
    $display("Address map test done");
    conclude();
  end
endmodule
